// ---- rtl/adc_control.sv ----
// Converter control: configuration registers, sequencing, result format and DMA addressing
//
// Overview of operation
// R1 - Resolution bit picks 10-bit/4 S/H or 12-bit/1
// R2 - Software changes resolution only while module off
// R3 - 10-bit mode samples up to four inputs together
// R4 - 12-bit mode uses one sample/hold only
// R5 - Input indices span 0 to 31
// R6 - Each converter instance has its own registers
// R7 - Done flag set starts the DMA transfer
// R8 - Bits 5:2 of register two set pointer rate
// R9 - Build-order bit: DMA gets stand-alone buffer address
// R10 - Otherwise scatter/gather address from input and size
// R11 - Software marks analog pins in pin config first
// R12 - Software picks voltage reference in register two
// R13 - Software sets clock divider in register three
// R14 - Software sets sample/hold count in register two
// R15 - Software sets trigger source and sample timing
// R16 - Software sets result format before turning on
// R17 - Software turns module on after configuration
// R18 - Software clears done flag, then sets priority
// R19 - Module on bit enables operation, resets to 0
// R20 - Format 00 zero-filled, 01 inverted-MSB sign extension
// R21 - Done flag sticks until cleared, may re-set
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adc_control #(
  parameter int UNIT = 0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic ext_trigger,
  input wire logic [adc_ctl_pkg::CODE_W-1:0] sample_codes [adc_ctl_pkg::NUM_SH],
  output logic [adc_ctl_pkg::INDEX_W-1:0] ch_select [adc_ctl_pkg::NUM_SH],
  output logic busy,
  adc_dma_if.converter link
);
  import adc_ctl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_SEND} state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers, one private set per instance [R6]
  logic [15:0] con1;
  logic [15:0] con2;
  logic [15:0] con3;
  logic [15:0] pcfg_low;
  logic [15:0] pcfg_high;
  logic [INDEX_W-1:0] chan_base;
  logic [2:0] dma_size_log2;
  logic [WORD_W-1:0] result [NUM_SH];
  state_t state;
  logic [CODE_W-1:0] held [NUM_SH];
  logic [15:0] timer;
  logic [1:0] send_ch;
  logic [3:0] seq_count;
  logic [DMA_ADDR_W-1:0] order_ptr;
  logic [DMA_ADDR_W-1:0] sg_offset;
  logic trig_q;

  logic module_on;
  logic twelve_bit;
  logic [2:0] nch;
  logic wr_con1;
  logic set_done;
  logic seq_last;
  logic auto_trig;
  logic sample_end;
  logic [15:0] tad_cycles;

  assign module_on = con1[CON1_ON];  // [R19]
  assign twelve_bit = con1[CON1_RES];
  assign wr_con1 = wr && addr == IDX_CON1;
  assign seq_last = seq_count == con2[CON2_RATE_LO +: 4];
  assign set_done = state == ST_CONVERT && timer == 16'h0000;
  assign auto_trig = con1[CON1_TRIG_LO +: 3] == TRIG_AUTO;
  // Manual and external triggers never run the sample timer, so they end sampling on their own event
  assign sample_end = state == ST_SAMPLE && (auto_trig ? timer == 16'h0000 :
                      (con1[CON1_TRIG_LO +: 3] == TRIG_MANUAL ? con1[CON1_START] : ext_trigger && !trig_q));

  // Single sample/hold in 12-bit mode; otherwise 1, 2 or 4 channels [R1] [R3] [R4]
  always_comb begin
    if (twelve_bit) begin
      nch = 3'h1;
    end else begin
      unique case (con2[CON2_CHANS_LO +: 2])
        2'h0: nch = 3'h1;
        2'h1: nch = 3'h2;
        default: nch = 3'h4;
      endcase
    end
  end

  always_comb begin
    tad_cycles = 16'({8'h00, con3[CON3_DIV_LO +: 8]} + 16'h0001);
  end

  // Result presentation [R20]
  function automatic logic [WORD_W-1:0] format_code(input logic [CODE_W-1:0] d, input logic wide,
                                                    input logic [1:0] result_format_field);
    logic [WORD_W-1:0] r;
    r = 16'h0000;
    if (wide) begin
      r = (result_format_field == 2'h1) ? {{5{~d[11]}}, d[10:0]} : {4'h0, d};
    end else begin
      r = (result_format_field == 2'h1) ? {{7{~d[9]}}, d[8:0]} : {6'h00, d[9:0]};
    end
    return r;
  endfunction : format_code

  ////////////////////////////////////////////////////////////////////////////////
  // Software port
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      con1 <= REG_RESET;  // [R19]
    end else begin
      if (wr_con1) begin
        con1[15:2] <= wdata[15:2] & CON1_MASK[15:2];
        // Resolution is frozen while the converter runs; software is expected to switch off first [R2]
        if (module_on) begin
          con1[CON1_RES] <= con1[CON1_RES];
        end
      end
      // Start bit clears itself once sampling ends
      if (wr_con1 && wdata[CON1_START] && module_on) begin
        con1[CON1_START] <= 1'b1;
      end else if (sample_end) begin
        con1[CON1_START] <= 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle [R21]
      if (set_done) begin
        con1[CON1_DONE] <= 1'b1;  // [R7]
      end else if (wr_con1 && !wdata[CON1_DONE]) begin
        con1[CON1_DONE] <= 1'b0;  // [R18]
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      con2 <= REG_RESET;
      con3 <= REG_RESET;
      pcfg_low <= REG_RESET;
      pcfg_high <= REG_RESET;
      chan_base <= '0;
      dma_size_log2 <= 3'h0;
    end else if (wr) begin
      unique case (addr)
        IDX_CON2: con2 <= wdata & CON2_MASK;  // [R8] [R12] [R14]
        IDX_CON3: con3 <= wdata & CON3_MASK;  // [R13] [R15]
        IDX_PCFG_LOW: pcfg_low <= wdata;  // [R11]
        IDX_PCFG_HIGH: pcfg_high <= wdata;
        IDX_CHAN_BASE: chan_base <= wdata[INDEX_W-1:0];  // [R5]
        IDX_DMA_SIZE: dma_size_log2 <= wdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        IDX_CON1: rdata <= con1;
        IDX_CON2: rdata <= con2;
        IDX_CON3: rdata <= con3;
        IDX_PCFG_LOW: rdata <= pcfg_low;
        IDX_PCFG_HIGH: rdata <= pcfg_high;
        IDX_CHAN_BASE: rdata <= {11'h000, chan_base};
        IDX_DMA_SIZE: rdata <= {13'h0000, dma_size_log2};
        IDX_STATUS: rdata <= {10'h000, state, seq_count};
        4'h8, 4'h9, 4'ha, 4'hb: rdata <= result[addr[1:0]];
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= ext_trigger;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      timer <= 16'h0000;
      send_ch <= 2'h0;
      busy <= 1'b0;
    end else if (!module_on) begin
      state <= ST_IDLE;  // [R19]
      timer <= 16'h0000;
      busy <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          state <= ST_SAMPLE;
          timer <= 16'({11'h000, con3[CON3_SAMP_LO +: 5]} * tad_cycles);
          busy <= 1'b1;
        end
        ST_SAMPLE: begin
          // Sampling ends by the start bit, the internal counter or the external trigger
          if (sample_end) begin
            state <= ST_CONVERT;
            timer <= 16'((twelve_bit ? TAD_12BIT : TAD_10BIT) * tad_cycles);
          end else if (auto_trig) begin
            timer <= timer - 16'h0001;
          end
        end
        ST_CONVERT: begin
          if (timer != 16'h0000) begin
            timer <= timer - 16'h0001;
          end else begin
            state <= ST_SEND;
            send_ch <= 2'h0;
          end
        end
        ST_SEND: begin
          if (link.xfer_valid && link.xfer_ready) begin
            if (3'(send_ch) + 3'h1 == nch) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
            send_ch <= send_ch + 2'h1;
          end
        end
      endcase
    end
  end

  // The selected sample/hold channels (k < nch) capture in one cycle [R3]; only channel 0 in 12-bit mode [R4]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < NUM_SH; k++) begin
        held[k] <= '0;
        result[k] <= 16'h0000;
        ch_select[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_SH; k++) begin
        ch_select[k] <= INDEX_W'(chan_base + INDEX_W'(k));  // [R5]
        if (sample_end && 3'(k) < nch) begin
          held[k] <= sample_codes[k];
        end
        if (set_done) begin
          result[k] <= (3'(k) < nch) ? format_code(held[k], twelve_bit, con1[CON1_RESULT_FORMAT_FIELD_LO +: 2]) : 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA addressing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seq_count <= 4'h0;
      order_ptr <= '0;
      sg_offset <= '0;
    end else if (!module_on) begin
      seq_count <= 4'h0;
      order_ptr <= '0;
      sg_offset <= '0;
    end else begin
      if (link.xfer_valid && link.xfer_ready) begin
        order_ptr <= order_ptr + 11'h001;  // [R9]
      end
      // The pointer advances once every rate+1 sequences [R8]
      if (state == ST_SEND && link.xfer_valid && link.xfer_ready && 3'(send_ch) + 3'h1 == nch) begin
        seq_count <= seq_last ? 4'h0 : seq_count + 4'h1;
        if (seq_last) begin
          sg_offset <= (sg_offset + 11'h001) & ((11'h001 << dma_size_log2) - 11'h001);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link.xfer_valid <= 1'b0;
      link.xfer_addr <= '0;
      link.xfer_data <= 16'h0000;
      link.done_pulse <= 1'b0;
    end else begin
      link.done_pulse <= set_done;  // [R7]
      if (state == ST_SEND && module_on && !(link.xfer_valid && link.xfer_ready && 3'(send_ch) + 3'h1 == nch)) begin
        link.xfer_valid <= 1'b1;
        link.xfer_data <= result[(link.xfer_valid && link.xfer_ready) ? send_ch + 2'h1 : send_ch];
        if (con1[CON1_BUILD]) begin
          link.xfer_addr <= (link.xfer_valid && link.xfer_ready) ? order_ptr + 11'h001 : order_ptr;  // [R9]
        end else begin
          // Input index scaled by the buffer size plus the running offset [R10]
          link.xfer_addr <= DMA_ADDR_W'(({6'h00, ch_select[(link.xfer_valid && link.xfer_ready) ?
                            send_ch + 2'h1 : send_ch]} << dma_size_log2) + sg_offset);
        end
      end else begin
        link.xfer_valid <= 1'b0;
      end
    end
  end
endmodule : adc_control

// ---- rtl/adc_ctl_pkg.sv ----
// Shared constants for the converter control block and its DMA partner
package adc_ctl_pkg;
  // Register indices on the software port
  localparam logic [3:0] IDX_CON1 = 4'h0;
  localparam logic [3:0] IDX_CON2 = 4'h1;
  localparam logic [3:0] IDX_CON3 = 4'h2;
  localparam logic [3:0] IDX_PCFG_LOW = 4'h3;
  localparam logic [3:0] IDX_PCFG_HIGH = 4'h4;
  localparam logic [3:0] IDX_CHAN_BASE = 4'h5;
  localparam logic [3:0] IDX_DMA_SIZE = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;
  localparam logic [3:0] IDX_RESULT0 = 4'h8;
  // Field positions in control_register_one
  localparam int CON1_ON = 15;
  localparam int CON1_BUILD = 12;
  localparam int CON1_RES = 10;
  localparam int CON1_RESULT_FORMAT_FIELD_LO = 8;
  localparam int CON1_TRIG_LO = 5;
  localparam int CON1_START = 1;
  localparam int CON1_DONE = 0;
  // Field positions in control_register_two and three
  localparam int CON2_CHANS_LO = 8;
  localparam int CON2_RATE_LO = 2;
  localparam int CON3_SAMP_LO = 8;
  localparam int CON3_DIV_LO = 0;
  // Writable bits of each register, reserved bits read as zero
  localparam logic [15:0] CON1_MASK = 16'h97ee;
  localparam logic [15:0] CON2_MASK = 16'he33c;
  localparam logic [15:0] CON3_MASK = 16'h1fff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Trigger source codes
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // Conversion length in conversion clock periods
  localparam int TAD_10BIT = 12;
  localparam int TAD_12BIT = 14;
  localparam int NUM_SH = 4;
  localparam int CODE_W = 12;
  localparam int INDEX_W = 5;
  localparam int DMA_ADDR_W = 11;
  localparam int WORD_W = 16;
endpackage : adc_ctl_pkg

// ---- rtl/adc_dma_if.sv ----
// Link between a converter control block and the DMA / interrupt side
`timescale 1ns/1ps
interface adc_dma_if;
  import adc_ctl_pkg::*;
  logic xfer_valid;
  logic xfer_ready;
  logic [DMA_ADDR_W-1:0] xfer_addr;
  logic [WORD_W-1:0] xfer_data;
  logic done_pulse;
  modport converter (output xfer_valid, output xfer_addr, output xfer_data, output done_pulse, input xfer_ready);
  modport dma (input xfer_valid, input xfer_addr, input xfer_data, input done_pulse, output xfer_ready);
endinterface : adc_dma_if

// ---- rtl/adc_dma_end.sv ----
// DMA channel and interrupt side: stores converter results and latches the done event
`timescale 1ns/1ps
module adc_dma_end #(
  parameter int DEPTH = 2048
) (
  input wire logic clock,
  input wire logic arst_n,
  adc_dma_if.dma link,
  input wire logic source_enable,
  input wire logic irq_clear,
  output logic irq_pending,
  input wire logic [adc_ctl_pkg::DMA_ADDR_W-1:0] mem_raddr,
  output logic [adc_ctl_pkg::WORD_W-1:0] mem_rdata,
  output logic [15:0] words_stored
);
  import adc_ctl_pkg::*;

  logic [WORD_W-1:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // Accept transfers only while this converter is the selected source [R7]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link.xfer_ready <= 1'b0;
    end else begin
      link.xfer_ready <= source_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (link.xfer_valid && link.xfer_ready) begin
      mem[link.xfer_addr] <= link.xfer_data;  // [R9] [R10]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_rdata <= 16'h0000;
      words_stored <= 16'h0000;
    end else begin
      mem_rdata <= mem[mem_raddr];
      if (link.xfer_valid && link.xfer_ready) begin
        words_stored <= words_stored + 16'h0001;
      end
    end
  end

  // A new done event beats a clear in the same cycle [R18] [R21]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_pending <= 1'b0;
    end else if (link.done_pulse && source_enable) begin
      irq_pending <= 1'b1;
    end else if (irq_clear) begin
      irq_pending <= 1'b0;
    end
  end
endmodule : adc_dma_end

// ---- dv/adc_link_properties.sv ----
// Concurrent checks on the link between the converter control and the DMA end
`timescale 1ns/1ps
module adc_link_properties (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic [adc_ctl_pkg::DMA_ADDR_W-1:0] xfer_addr,
  input wire logic [adc_ctl_pkg::WORD_W-1:0] xfer_data,
  input wire logic done_pulse
);
  import adc_ctl_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Words accepted since the last done pulse
  logic [3:0] words;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      words <= 4'h0;
    end else if (done_pulse) begin
      words <= 4'h0;
    end else if (xfer_valid && xfer_ready) begin
      words <= words + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence word_wait;
    xfer_valid && !xfer_ready;
  endsequence
  sequence send_start;
    !xfer_valid ##1 xfer_valid;
  endsequence
  chk_valid_held: assert property (word_wait |=> xfer_valid)
    else $error("valid dropped before acceptance");
  chk_addr_stable: assert property (word_wait |=> $stable(xfer_addr))
    else $error("address moved while stalled");
  chk_data_stable: assert property (word_wait |=> $stable(xfer_data))
    else $error("data moved while stalled");
  chk_fall_accepted: assert property ($fell(xfer_valid) |-> $past(xfer_valid && xfer_ready))
    else $error("valid fell without acceptance");
  chk_pulse_single: assert property (done_pulse |=> !done_pulse)
    else $error("done pulse longer than one cycle");
  chk_send_after_done: assert property (done_pulse |-> send_start)
    else $error("transfer did not follow done pulse");
  chk_data_format: assert property (xfer_valid |-> (xfer_data[15:12] == 4'h0 || xfer_data[15:12] == 4'hf))
    else $error("upper result bits not a fill pattern");
  chk_word_cap: assert property (words <= 4'h4)
    else $error("more than four words in one sequence");
endmodule : adc_link_properties

// ---- dv/sar_adc_config_dma_control_tb.sv ----
// Self-checking bench for the converter control block and its DMA end
`timescale 1ns/1ps
module sar_adc_config_dma_control_tb;
  import adc_ctl_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic ext_trigger = 1'b0;
  logic [CODE_W-1:0] sample_codes [NUM_SH];
  logic [INDEX_W-1:0] ch_select [NUM_SH];
  logic busy;
  logic source_enable = 1'b0;
  logic irq_clear = 1'b0;
  logic irq_pending;
  logic [DMA_ADDR_W-1:0] mem_raddr = 11'h000;
  logic [WORD_W-1:0] mem_rdata;
  logic [15:0] words_stored;
  int error_cnt = 0;
  int check_count = 0;
  integer seed = 61;
  int sg_off = 0;
  int ptr = 0;
  int sq = 0;
  int stored = 0;
  logic [DMA_ADDR_W-1:0] got_a [$];
  logic [WORD_W-1:0] got_d [$];
  always #10 clock = ~clock;
  adc_dma_if link ();
  adc_control #(.UNIT(0)) adc_control_i (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_trigger(ext_trigger), .sample_codes(sample_codes), .ch_select(ch_select),
    .busy(busy), .link(link));
  adc_dma_end #(.DEPTH(2048)) adc_dma_end_i (.clock(clock), .arst_n(arst_n), .link(link),
    .source_enable(source_enable), .irq_clear(irq_clear), .irq_pending(irq_pending), .mem_raddr(mem_raddr),
    .mem_rdata(mem_rdata), .words_stored(words_stored));
  adc_link_properties adc_link_properties_i (.clock(clock), .arst_n(arst_n), .xfer_valid(link.xfer_valid),
    .xfer_ready(link.xfer_ready), .xfer_addr(link.xfer_addr), .xfer_data(link.xfer_data),
    .done_pulse(link.done_pulse));
  always @(posedge clock) begin
    if (link.xfer_valid && link.xfer_ready) begin
      got_a.push_back(link.xfer_addr);
      got_d.push_back(link.xfer_data);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk("register read", e, rdata);
  endtask : rd_chk
  function automatic logic [15:0] fmt(logic [11:0] d, bit b12, logic [1:0] f);
    if (b12) return (f == 2'h1) ? {{5{~d[11]}}, d[10:0]} : {4'h0, d};
    return (f == 2'h1) ? {{7{~d[9]}}, d[8:0]} : {6'h00, d[9:0]};
  endfunction : fmt
  // Model: base 30 wraps past input 31, buffer size 4 words per input, offset steps every second sequence
  task automatic run_seq(input int nch, input bit bld, input bit b12, input logic [1:0] f, input logic [15:0] con1);
    int n;
    int idx;
    @(posedge clock);
    foreach (sample_codes[k]) sample_codes[k] <= 12'($random(seed));
    wr_reg(IDX_CON1, con1 | 16'h0002);
    @(posedge clock);
    ext_trigger <= 1'b1;
    @(posedge clock);
    ext_trigger <= 1'b0;
    for (n = 0; n < 400 && link.done_pulse !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (source_enable !== 1'b1) begin
      repeat (5) @(posedge clock);
      chk("stalled words", 16'h0000, 16'(got_a.size()));
      chk("irq while deselected", 16'h0000, 16'(irq_pending));
      source_enable <= 1'b1;
    end
    for (n = 0; n < 400 && busy !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    chk("word count", 16'(nch), 16'(got_a.size()));
    stored = stored + nch;
    chk("words stored", 16'(stored), words_stored);
    for (int k = 0; k < nch && k < got_a.size(); k++) begin
      idx = (30 + k) % 32;
      chk("channel index", 16'(idx), 16'(ch_select[k]));
      chk("dma address", bld ? 16'(ptr) : 16'(((idx << 2) + sg_off) & 'h7ff), 16'(got_a[k]));
      chk("dma data", fmt(sample_codes[k], b12, f), got_d[k]);
      rd_chk(4'(IDX_RESULT0 + k), fmt(sample_codes[k], b12, f));
      @(posedge clock);
      mem_raddr <= got_a[k];
      @(posedge clock);
      #1;
      chk("dma memory", fmt(sample_codes[k], b12, f), mem_rdata);
      if (bld) ptr++;
    end
    if (!bld) begin
      sq++;
      if (sq == 2) begin
        sq = 0;
        sg_off = (sg_off + 1) % 4;
      end
    end
    got_a.delete();
    got_d.delete();
  endtask : run_seq
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (sample_codes[k]) sample_codes[k] = 12'h000;
    fork
      begin
        #1000000;
        error_cnt++;
        wrap_up();
      end
    join_none
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(IDX_CON1, 16'h0000);
    rd_chk(4'hf, 16'h0000);
    wr_reg(IDX_PCFG_LOW, 16'hffff);
    rd_chk(IDX_PCFG_LOW, 16'hffff);
    wr_reg(IDX_CHAN_BASE, 16'h001e);
    wr_reg(IDX_CON2, 16'h2304);
    rd_chk(IDX_CON2, 16'h2304);
    wr_reg(IDX_CON3, 16'h0100);
    wr_reg(IDX_DMA_SIZE, 16'h0002);
    source_enable <= 1'b1;
    wr_reg(IDX_CON1, 16'h8100);
    wr_reg(IDX_CON1, 16'h8500);
    rd_chk(IDX_CON1, 16'h8100);
    run_seq(4, 1'b0, 1'b0, 2'h1, 16'h8100);
    run_seq(4, 1'b0, 1'b0, 2'h0, 16'h8001);
    chk("irq pending", 16'h0001, 16'(irq_pending));
    rd_chk(IDX_CON1, 16'h8001);
    run_seq(4, 1'b0, 1'b0, 2'h1, 16'h8180);
    wr_reg(IDX_CON1, 16'h8000);
    rd_chk(IDX_CON1, 16'h8000);
    @(posedge clock);
    irq_clear <= 1'b1;
    @(posedge clock);
    irq_clear <= 1'b0;
    @(posedge clock);
    #1;
    chk("irq cleared", 16'h0000, 16'(irq_pending));
    // Resolution may change only while off; ready is held low for the first 12-bit run
    wr_reg(IDX_CON1, 16'h0000);
    wr_reg(IDX_CON1, 16'h1400);
    wr_reg(IDX_CON1, 16'h9401);
    source_enable <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      run_seq(1, 1'b1, 1'b1, 2'(f), 16'h9401 | (16'(f) << 8));
    end
    rd_chk(IDX_CON1, 16'h9701);
    rd_chk(IDX_STATUS, 16'h0010);
    wrap_up();
  end
endmodule : sar_adc_config_dma_control_tb
